// >>> logic/bioc_pkg.sv
// Purpose: Constants for the board I/O select and control block.
// Assumes: Host I/O cycles arrive as pins synchronised inside the block.
// Notes: Offsets are host I/O port addresses, 10 bits wide.
package bioc_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFF_STANDBY_TRIGGER = 10'h01C;
  localparam logic [9:0] OFF_STANDBY_ARM = 10'h01E;
  localparam logic [9:0] OFF_SYSTEM_CONTROL = 10'h061;
  localparam logic [9:0] OFF_SYSTEM_STATUS = 10'h062;
  localparam logic [9:0] OFF_PERIPHERAL_SELECT = 10'h065;
  localparam logic [9:0] OFF_MISC_CONTROL_STATUS = 10'h0D0;
  localparam logic [9:0] OFF_DISK_DIAGNOSTIC = 10'h0D1;
  localparam logic [9:0] OFF_INDICATOR_CONTROL = 10'h0D7;
  localparam logic [9:0] OFF_FLOPPY_READBACK_A = 10'h3F0;
  localparam logic [9:0] OFF_FLOPPY_READBACK_B = 10'h3F1;
  // Floppy controller window (3F0h..3F7h) and the two disk windows.
  localparam logic [9:0] FLOPPY_BASE = 10'h3F0;
  localparam logic [9:0] FLOPPY_LAST = 10'h3F7;
  localparam logic [9:0] DISK_AT_BASE = 10'h1F0;
  localparam logic [9:0] DISK_AT_LAST = 10'h1F7;
  localparam logic [9:0] DISK_LEGACY_BASE = 10'h320;
  localparam logic [9:0] DISK_LEGACY_LAST = 10'h327;
  // Peripheral select fields.
  localparam int PSEL_PAR_OE = 7;
  localparam int PSEL_SERIAL1 = 4;
  localparam int PSEL_FLOPPY = 3;
  localparam int PSEL_VIDEO = 2;
  localparam int PSEL_PARALLEL = 1;
  localparam int PSEL_DISK = 0;
  localparam logic [7:0] PSEL_WMASK = 8'h9F;
  localparam logic [7:0] PSEL_RESET = 8'h00;
  // System control fields.
  localparam int SCTL_CHK_DIS = 5;
  localparam int SCTL_PAR_DIS = 4;
  localparam int SCTL_SPK_GATE = 1;
  localparam int SCTL_TMR2_EN = 0;
  localparam logic [7:0] SCTL_WMASK = 8'h33;
  localparam logic [7:0] SCTL_RESET = 8'h00;
  // System status fields.
  localparam int SSTS_PAR_ERR = 7;
  localparam int SSTS_CHK_ERR = 6;
  localparam int SSTS_TMR2_OUT = 5;
  localparam int SSTS_NO_DISK = 2;
  localparam int SSTS_COPRO = 1;
  localparam logic NO_DISK_RESET = 1'b1;
  localparam logic COPRO_RESET = 1'b0;
  // Miscellaneous control fields.
  localparam int MISC_DRV_TYPE = 7;
  localparam int MISC_RTC_CLK = 6;
  localparam int MISC_SER2_EN = 5;
  localparam int MISC_FORCE_ACK2 = 4;
  localparam int MISC_RTC_RST = 3;
  localparam logic [7:0] MISC_WMASK = 8'hB0;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // Disk diagnostic and indicator fields.
  localparam int DIAG_LEGACY_WIN = 1;
  localparam int DIAG_FORCE_ACK3 = 0;
  localparam logic [7:0] DIAG_WMASK = 8'h03;
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam int IND_ON = 0;
  localparam logic [7:0] IND_WMASK = 8'h01;
  localparam logic [7:0] IND_RESET = 8'h00;
  localparam int STANDBY_ARM_BIT = 0;
endpackage

// >>> logic/bioc_top.sv
// Purpose: Board I/O select, decode, diagnostic and standby control registers.
// Assumes: Host strobes, address and data are asynchronous pins; two flops sync them.
// Notes: Decodes act on synchronised cycles, so outputs lag the pins by three clocks; the DMA 2 term of the floppy buffer enables lags by four.
`timescale 1ns/1ps

// How it works
// R1: Coprocessor bit writable, resets to zero.
// R2: Status bit 0 reads zero always.
// R3: Selected floppy or disk gets chip select, channel blocked.
// R4: Deselected peripheral: no select, channel passes.
// R5: Peripheral select clears on reset.
// R6: Peripheral select bit map as tabulated.
// R7: Decode floppy, drive select and buffer enables.
// R8: Readback A returns floppy status bits.
// R9: Readback B returns drive and latch bits.
// R10: Hard disk window asserts disk select.
// R11: Disk DMA on channel 3 asserts disk select.
// R12: Host writes arm then reads trigger.
// R13: Standby held while trigger read persists.
// R14: Standby ends when trigger read ends.
// R15: Misc bit 7 drives drive type pin.
// R16: Misc bits 6,3 show calendar clock, reset.
// R17: Misc bit 5 enables second serial.
// R18: Misc bit 4 forces DMA 2 acknowledge.
// R19: Diagnostic bit 1 picks disk window.
// R20: Diagnostic bit 0 forces DMA 3 acknowledge.
// R21: Indicator bit 0 drives indicator output.
// R22: System control bits 5,4,1,0 mapped.
// R23: System status bits 7,6,5,2,1 mapped.
// R24: No-disk bit writable, resets to one.
// R25: Unused bits read zero, ignore writes.
module bioc_top
  import bioc_pkg::*;
(
  input wire logic CLK_I, // 125 MHz clock.
  input wire logic RESETN_I, // Asynchronous reset, active low.
  input wire logic CE_I, // Clock enable; freezes all state when low.
  input wire logic IOR_N_I, // Host I/O read strobe, active low.
  input wire logic IOW_N_I, // Host I/O write strobe, active low.
  input wire logic [ADDR_W-1:0] ADDR_I, // Host I/O address.
  input wire logic [7:0] DATA_I, // Host write data.
  input wire logic DMA_ACK2_I, // DMA channel 2 acknowledge from the DMA controller.
  input wire logic DMA_ACK3_I, // DMA channel 3 acknowledge from the DMA controller.
  input wire logic PARITY_ERR_I, // On-board memory parity error.
  input wire logic CHANNEL_CHECK_IN_I, // Expansion channel check, active high.
  input wire logic TIMER2_OUT_I, // Timer 2 output.
  input wire logic RTC_CLK_I, // Clock-calendar input clock level.
  input wire logic RTC_RST_I, // Clock-calendar reset level.
  input wire logic [7:0] FLOPPY_STAT_A_I, // Floppy status for readback A.
  input wire logic [7:0] FLOPPY_STAT_B_I, // Floppy status for readback B.
  output logic [7:0] DATA_O, // Host read data.
  output logic DATA_OE_O, // High while the block drives the data bus.
  output logic CHAN_IOR_N_O, // Read strobe to expansion channel, active low.
  output logic CHAN_IOW_N_O, // Write strobe to expansion channel, active low.
  output logic FLOPPY_CHIP_SELECT_O, // Floppy controller select, active high.
  output logic FLOPPY_BUFFER_ENABLE_A_N_O, // Floppy buffer enable A, active low.
  output logic FLOPPY_BUFFER_ENABLE_B_N_O, // Floppy buffer enable B, active low.
  output logic HARD_DISK_SELECT_N_O, // Hard disk select, active low.
  output logic VIDEO_SEL_O, // Video controller select.
  output logic PARALLEL_SEL_O, // Parallel port select.
  output logic PARALLEL_OE_O, // Parallel port output enable.
  output logic SERIAL1_SEL_O, // Serial port 1 select.
  output logic SERIAL2_EN_O, // Second serial controller enable.
  output logic DMA_ACK_CH2_O, // DMA channel 2 acknowledge, forced or passed.
  output logic DMA_ACK_CH3_O, // DMA channel 3 acknowledge, forced or passed.
  output logic DRIVE_TYPE_OUT_O, // Drive type pin level.
  output logic INDICATOR_O, // Indicator driver, high means on.
  output logic CHK_DISABLE_O, // Channel-check error disable.
  output logic PARITY_DISABLE_O, // On-board parity check disable.
  output logic TIMER2_GATE_O, // Timer 2 gate input.
  output logic SPEAKER_O, // Gated timer 2 output.
  output logic STANDBY_O // High while the block is in standby.
);

  // Synchroniser stages; stage 1 is read only by stage 2.
  logic [ADDR_W+8+7-1:0] s1_q, s2_q;
  logic ior_n, iow_n, chk, par, tmr2, rtcc, rtcr, ack2, ack3;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdat;
  logic [7:0] fa_s1_q, fa_q, fb_s1_q, fb_q;
  logic iow_n_d1_q;
  logic [7:0] psel_q, sctl_q, misc_q, diag_q, ind_q;
  logic no_disk_q, copro_q, armed;
  logic wr_pulse, rd_act, floppy_hit, disk_hit, psel_owned;
  logic [7:0] rdata;
  typedef enum logic [1:0] {BIOC_RUN, BIOC_ARMED, BIOC_STANDBY} bioc_state_t;
  bioc_state_t st_q;

  // True when an address lies in an inclusive window.
  function automatic logic in_win(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // Two-flop synchronisers for every asynchronous pin except the two DMA acknowledges.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_q <= '1;
      s2_q <= '1;
      fa_s1_q <= 8'h00;
      fa_q <= 8'h00;
      fb_s1_q <= 8'h00;
      fb_q <= 8'h00;
    end else if (CE_I) begin
      s1_q <= {IOR_N_I, IOW_N_I, ADDR_I, DATA_I, CHANNEL_CHECK_IN_I, PARITY_ERR_I, TIMER2_OUT_I,
               RTC_CLK_I, RTC_RST_I};
      s2_q <= s1_q;
      fa_s1_q <= FLOPPY_STAT_A_I;
      fa_q <= fa_s1_q;
      fb_s1_q <= FLOPPY_STAT_B_I;
      fb_q <= fb_s1_q;
    end
  end

  // The two acknowledges are synchronised separately so their reset is idle-low.
  logic [1:0] ack_s1_q, ack_s2_q;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_s1_q <= 2'h0;
      ack_s2_q <= 2'h0;
    end else if (CE_I) begin
      ack_s1_q <= {DMA_ACK3_I, DMA_ACK2_I};
      ack_s2_q <= ack_s1_q;
    end
  end

  assign {ior_n, iow_n, addr, wdat, chk, par, tmr2, rtcc, rtcr} = s2_q;
  assign {ack3, ack2} = ack_s2_q;

  // A write takes effect once, at the rising edge of the synchronised write strobe,
  // when address and data have long been stable.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      iow_n_d1_q <= 1'b1;
    end else if (CE_I) begin
      iow_n_d1_q <= iow_n;
    end
  end
  assign wr_pulse = !iow_n_d1_q && iow_n;
  assign rd_act = !ior_n;

  // Address windows; the disk window depends on the diagnostic register.
  assign floppy_hit = in_win(addr, FLOPPY_BASE, FLOPPY_LAST); // see R7
  assign disk_hit = diag_q[DIAG_LEGACY_WIN] ? in_win(addr, DISK_LEGACY_BASE, DISK_LEGACY_LAST)
                                            : in_win(addr, DISK_AT_BASE, DISK_AT_LAST); // see R19 see R10
  // Enabled floppy and disk controllers claim their window cycles away from the channel.
  assign psel_owned = (psel_q[PSEL_FLOPPY] && floppy_hit) || (psel_q[PSEL_DISK] && disk_hit); // see R3 see R4

  // Peripheral select register; reserved bits 6 and 5 stay zero.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      psel_q <= PSEL_RESET; // see R5
    end else if (CE_I && wr_pulse && addr == OFF_PERIPHERAL_SELECT) begin
      psel_q <= wdat & PSEL_WMASK; // see R6 see R25
    end
  end

  // System control register.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sctl_q <= SCTL_RESET;
    end else if (CE_I && wr_pulse && addr == OFF_SYSTEM_CONTROL) begin
      sctl_q <= wdat & SCTL_WMASK; // see R22
    end
  end

  // Firmware-owned status flags; bit 0 and the other read-only bits drop writes.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      no_disk_q <= NO_DISK_RESET; // see R24
      copro_q <= COPRO_RESET; // see R1
    end else if (CE_I && wr_pulse && addr == OFF_SYSTEM_STATUS) begin
      no_disk_q <= wdat[SSTS_NO_DISK]; // see R24
      copro_q <= wdat[SSTS_COPRO]; // see R1 see R2
    end
  end

  // Miscellaneous, diagnostic and indicator registers.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      misc_q <= MISC_RESET;
      diag_q <= DIAG_RESET;
      ind_q <= IND_RESET;
    end else if (CE_I && wr_pulse) begin
      if (addr == OFF_MISC_CONTROL_STATUS) begin
        misc_q <= wdat & MISC_WMASK; // see R15 see R17 see R18
      end else if (addr == OFF_DISK_DIAGNOSTIC) begin
        diag_q <= wdat & DIAG_WMASK; // see R19 see R20
      end else if (addr == OFF_INDICATOR_CONTROL) begin
        ind_q <= wdat & IND_WMASK; // see R21
      end
    end
  end

  // Standby sequencer: an arm write, then a trigger read that holds the block static.
  // Any other cycle between arm and trigger disarms, so a stray read cannot sleep the chip.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_q <= BIOC_RUN;
    end else if (CE_I) begin
      case (st_q)
        BIOC_RUN: begin
          if (wr_pulse && addr == OFF_STANDBY_ARM && wdat[STANDBY_ARM_BIT]) begin
            st_q <= BIOC_ARMED; // see R12
          end
        end
        BIOC_ARMED: begin
          if (rd_act && addr == OFF_STANDBY_TRIGGER) begin
            st_q <= BIOC_STANDBY; // see R13
          end else if (wr_pulse || rd_act) begin
            st_q <= BIOC_RUN;
          end
        end
        BIOC_STANDBY: begin
          if (!rd_act || addr != OFF_STANDBY_TRIGGER) begin
            st_q <= BIOC_RUN; // see R14
          end
        end
        default: begin
          st_q <= BIOC_RUN;
        end
      endcase
    end
  end
  assign armed = (st_q == BIOC_ARMED);

  // Read data mux; unmapped and unused bits read zero.
  always_comb begin
    rdata = 8'h00;
    if (addr == OFF_SYSTEM_CONTROL) begin
      rdata = sctl_q;
    end else if (addr == OFF_SYSTEM_STATUS) begin
      rdata[SSTS_PAR_ERR] = par; // see R23
      rdata[SSTS_CHK_ERR] = chk;
      rdata[SSTS_TMR2_OUT] = tmr2;
      rdata[SSTS_NO_DISK] = no_disk_q;
      rdata[SSTS_COPRO] = copro_q; // see R2
    end else if (addr == OFF_PERIPHERAL_SELECT) begin
      rdata = psel_q;
    end else if (addr == OFF_MISC_CONTROL_STATUS) begin
      rdata = misc_q;
      rdata[MISC_RTC_CLK] = rtcc; // see R16
      rdata[MISC_RTC_RST] = rtcr;
    end else if (addr == OFF_DISK_DIAGNOSTIC) begin
      rdata = diag_q;
    end else if (addr == OFF_INDICATOR_CONTROL) begin
      rdata = ind_q;
    end else if (addr == OFF_FLOPPY_READBACK_A) begin
      rdata = fa_q; // see R8
    end else if (addr == OFF_FLOPPY_READBACK_B) begin
      rdata = {1'b0, fb_q[6:0]}; // see R9
    end
  end

  // True when a read targets one of this block's own readable ports.
  function automatic logic own_port(input logic [ADDR_W-1:0] a);
    own_port = (a == OFF_SYSTEM_CONTROL) || (a == OFF_SYSTEM_STATUS) || (a == OFF_PERIPHERAL_SELECT) ||
               (a == OFF_MISC_CONTROL_STATUS) || (a == OFF_DISK_DIAGNOSTIC) ||
               (a == OFF_INDICATOR_CONTROL) || (a == OFF_FLOPPY_READBACK_A) ||
               (a == OFF_FLOPPY_READBACK_B);
  endfunction

  // Bus-facing outputs, registered. Strobes pass to the channel unless claimed.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DATA_O <= 8'h00;
      DATA_OE_O <= 1'b0;
      CHAN_IOR_N_O <= 1'b1;
      CHAN_IOW_N_O <= 1'b1;
      FLOPPY_CHIP_SELECT_O <= 1'b0;
      FLOPPY_BUFFER_ENABLE_A_N_O <= 1'b1;
      FLOPPY_BUFFER_ENABLE_B_N_O <= 1'b1;
      HARD_DISK_SELECT_N_O <= 1'b1;
      VIDEO_SEL_O <= 1'b0;
      PARALLEL_SEL_O <= 1'b0;
      SERIAL1_SEL_O <= 1'b0;
    end else if (CE_I) begin
      DATA_O <= rd_act ? rdata : 8'h00;
      DATA_OE_O <= rd_act && own_port(addr);
      CHAN_IOR_N_O <= ior_n || psel_owned; // see R3 see R4
      CHAN_IOW_N_O <= iow_n || psel_owned; // see R3 see R4
      FLOPPY_CHIP_SELECT_O <= psel_q[PSEL_FLOPPY] && floppy_hit && (rd_act || !iow_n); // see R7
      // Buffers steer during floppy port cycles and DMA channel 2 cycles.
      FLOPPY_BUFFER_ENABLE_A_N_O <= !(psel_q[PSEL_FLOPPY] &&
        ((floppy_hit && rd_act) || (DMA_ACK_CH2_O && !iow_n))); // see R7
      FLOPPY_BUFFER_ENABLE_B_N_O <= !(psel_q[PSEL_FLOPPY] &&
        ((floppy_hit && !iow_n) || (DMA_ACK_CH2_O && rd_act))); // see R7
      // Disk select covers port cycles and DMA channel 3 cycles. It uses the same acknowledge
      // term as DMA_ACK_CH3_O, so select and acknowledge change on the same edge.
      HARD_DISK_SELECT_N_O <= !(psel_q[PSEL_DISK] &&
        ((disk_hit && (rd_act || !iow_n)) || ack3 || diag_q[DIAG_FORCE_ACK3])); // see R10 see R11
      VIDEO_SEL_O <= psel_q[PSEL_VIDEO]; // see R6
      PARALLEL_SEL_O <= psel_q[PSEL_PARALLEL];
      SERIAL1_SEL_O <= psel_q[PSEL_SERIAL1];
    end
  end

  // Control-level outputs, registered from the register fields, the acknowledge and timer 2 inputs, and the standby sequencer.
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PARALLEL_OE_O <= 1'b0;
      SERIAL2_EN_O <= 1'b0;
      DMA_ACK_CH2_O <= 1'b0;
      DMA_ACK_CH3_O <= 1'b0;
      DRIVE_TYPE_OUT_O <= 1'b0;
      INDICATOR_O <= 1'b0;
      CHK_DISABLE_O <= 1'b0;
      PARITY_DISABLE_O <= 1'b0;
      TIMER2_GATE_O <= 1'b0;
      SPEAKER_O <= 1'b0;
      STANDBY_O <= 1'b0;
    end else if (CE_I) begin
      PARALLEL_OE_O <= psel_q[PSEL_PAR_OE];
      SERIAL2_EN_O <= misc_q[MISC_SER2_EN]; // see R17
      DMA_ACK_CH2_O <= ack2 || misc_q[MISC_FORCE_ACK2]; // see R18
      DMA_ACK_CH3_O <= ack3 || diag_q[DIAG_FORCE_ACK3]; // see R20 see R11
      DRIVE_TYPE_OUT_O <= misc_q[MISC_DRV_TYPE]; // see R15
      INDICATOR_O <= ind_q[IND_ON]; // see R21
      CHK_DISABLE_O <= sctl_q[SCTL_CHK_DIS]; // see R22
      PARITY_DISABLE_O <= sctl_q[SCTL_PAR_DIS];
      TIMER2_GATE_O <= sctl_q[SCTL_TMR2_EN];
      SPEAKER_O <= tmr2 && sctl_q[SCTL_SPK_GATE];
      // Standby holds for the whole trigger read; dynamic logic outside keys off it.
      // It mirrors the next state, so it drops on the edge where the sequencer leaves standby.
      STANDBY_O <= rd_act && (addr == OFF_STANDBY_TRIGGER) &&
                   (armed || (st_q == BIOC_STANDBY)); // see R13 see R14
    end
  end

endmodule

// >>> dv/bioc_top_sva.sv
// Purpose: Port-level checks for the board I/O select and control block.
// Assumes: Outputs lag the host pins by three clocks, as the synchronisers impose.
// Notes: Select, standby and open-read windows are exact, so an extra pipeline stage is caught; acknowledge and speaker windows have a clock of slack.
`timescale 1ns/1ps
module bioc_top_sva
  import bioc_pkg::*;
(
  input wire logic CLK_I, // Clock.
  input wire logic RESETN_I, // Reset, active low.
  input wire logic IOR_N_I, // Host read strobe.
  input wire logic [ADDR_W-1:0] ADDR_I, // Host address.
  input wire logic DMA_ACK2_I, // DMA 2 acknowledge in.
  input wire logic DMA_ACK3_I, // DMA 3 acknowledge in.
  input wire logic TIMER2_OUT_I, // Timer 2 output in.
  input wire logic CHAN_IOR_N_O, // Channel read strobe.
  input wire logic CHAN_IOW_N_O, // Channel write strobe.
  input wire logic FLOPPY_CHIP_SELECT_O, // Floppy select.
  input wire logic HARD_DISK_SELECT_N_O, // Disk select.
  input wire logic DMA_ACK_CH2_O, // DMA 2 acknowledge out.
  input wire logic DMA_ACK_CH3_O, // DMA 3 acknowledge out.
  input wire logic SPEAKER_O, // Gated timer output.
  input wire logic STANDBY_O, // Standby flag.
  input wire logic VIDEO_SEL_O, // Video select.
  input wire logic PARALLEL_SEL_O, // Parallel select.
  input wire logic PARALLEL_OE_O, // Parallel output enable.
  input wire logic SERIAL1_SEL_O // Serial 1 select.
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // A read strobe idle for four clocks has flushed the pipeline.
  sequence rd_idle_s;
    IOR_N_I[*4];
  endsequence
  // A read of an address that nothing on the board claims.
  sequence rd_open_s;
    (!IOR_N_I && ADDR_I == 10'h3EF)[*4];
  endsequence
  a_floppy_blocks_chan: assert property (FLOPPY_CHIP_SELECT_O |-> CHAN_IOR_N_O && CHAN_IOW_N_O)
    else $error("channel strobe during floppy select");
  a_disk_blocks_chan: assert property (!HARD_DISK_SELECT_N_O && !DMA_ACK_CH3_O |-> CHAN_IOR_N_O && CHAN_IOW_N_O)
    else $error("channel strobe during disk select");
  a_floppy_sel_window: assert property (FLOPPY_CHIP_SELECT_O |-> $past(ADDR_I, 3) inside {[FLOPPY_BASE:FLOPPY_LAST]})
    else $error("floppy select outside its window");
  a_disk_sel_window: assert property (!HARD_DISK_SELECT_N_O && !DMA_ACK_CH3_O |-> $past(ADDR_I, 3) inside
    {[DISK_AT_BASE:DISK_AT_LAST], [DISK_LEGACY_BASE:DISK_LEGACY_LAST]})
    else $error("disk select outside its windows");
  a_ack2_passes: assert property (DMA_ACK2_I[*5] |-> DMA_ACK_CH2_O)
    else $error("DMA 2 acknowledge not passed");
  a_ack3_passes: assert property (DMA_ACK3_I[*5] |-> DMA_ACK_CH3_O)
    else $error("DMA 3 acknowledge not passed");
  a_speaker_gated: assert property ((!TIMER2_OUT_I)[*5] |-> !SPEAKER_O)
    else $error("speaker high with timer low");
  a_standby_exit: assert property (rd_idle_s |-> !STANDBY_O)
    else $error("standby held without a read");
  a_open_read_passes: assert property (rd_open_s |-> !CHAN_IOR_N_O)
    else $error("unclaimed read not passed to channel");
  a_reset_selects_clear: assert property ($rose(RESETN_I) |-> !(VIDEO_SEL_O || PARALLEL_SEL_O ||
    SERIAL1_SEL_O || PARALLEL_OE_O))
    else $error("peripheral select not clear after reset");
endmodule

bind bioc_top bioc_top_sva u_sva (.*);

// >>> dv/bioc_chan_model.sv
// Purpose: Expansion I/O channel stand-in that counts the cycles handed to it.
// Assumes: Channel strobes are active-low levels driven by the block.
// Notes: It never stalls, because the block has no ready input that could slow it.
`timescale 1ns/1ps
module bioc_chan_model (
  input wire logic clk_i, // Bench clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic ior_n_i, // Channel read strobe, active low.
  input wire logic iow_n_i, // Channel write strobe, active low.
  output int rd_cnt_o, // Channel reads seen.
  output int wr_cnt_o // Channel writes seen.
);
  logic ior_q, iow_q;
  // One falling edge of a strobe is one cycle that reached the channel.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      rd_cnt_o <= 0;
      wr_cnt_o <= 0;
    end else begin
      ior_q <= ior_n_i;
      iow_q <= iow_n_i;
      if (ior_q && !ior_n_i) rd_cnt_o <= rd_cnt_o + 1;
      if (iow_q && !iow_n_i) wr_cnt_o <= wr_cnt_o + 1;
    end
  end
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the board I/O select and control block.
// Assumes: Host pins change at the falling clock edge and are held five clocks, ten for the standby trigger read.
// Notes: Live status inputs and register data are random from a fixed seed.
`timescale 1ns/1ps
module tb_top;
  import bioc_pkg::*;
  logic CLK_I = 1'b0, RESETN_I = 1'b0, CE_I = 1'b1, IOR_N_I = 1'b1, IOW_N_I = 1'b1;
  logic [9:0] ADDR_I = 10'h000;
  logic [7:0] DATA_I = 8'h00, FLOPPY_STAT_A_I = 8'h00, FLOPPY_STAT_B_I = 8'h00, DATA_O;
  logic DMA_ACK2_I = 1'b0, DMA_ACK3_I = 1'b0, PARITY_ERR_I = 1'b0, CHANNEL_CHECK_IN_I = 1'b0;
  logic TIMER2_OUT_I = 1'b0, RTC_CLK_I = 1'b0, RTC_RST_I = 1'b0;
  logic DATA_OE_O, CHAN_IOR_N_O, CHAN_IOW_N_O, FLOPPY_CHIP_SELECT_O, FLOPPY_BUFFER_ENABLE_A_N_O;
  logic FLOPPY_BUFFER_ENABLE_B_N_O, HARD_DISK_SELECT_N_O, VIDEO_SEL_O, PARALLEL_SEL_O, PARALLEL_OE_O;
  logic SERIAL1_SEL_O, SERIAL2_EN_O, DMA_ACK_CH2_O, DMA_ACK_CH3_O, DRIVE_TYPE_OUT_O, INDICATOR_O;
  logic CHK_DISABLE_O, PARITY_DISABLE_O, TIMER2_GATE_O, SPEAKER_O, STANDBY_O;
  int errors = 0, num_checks = 0, cyc = 0, ch_rd, ch_wr;
  logic [7:0] rd_d;
  logic rd_oe, s_fcs, s_hds_n, s_bufa_n, s_bufb_n, s_sb;
  // Shadows of control, status, select, misc, diagnostic and indicator.
  logic [7:0] sh [6] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [9:0] REGS [6] = '{OFF_SYSTEM_CONTROL, OFF_SYSTEM_STATUS, OFF_PERIPHERAL_SELECT,
    OFF_MISC_CONTROL_STATUS, OFF_DISK_DIAGNOSTIC, OFF_INDICATOR_CONTROL};
  localparam logic [7:0] MASKS [6] = '{SCTL_WMASK, 8'h06, PSEL_WMASK, MISC_WMASK, DIAG_WMASK, IND_WMASK};

  bioc_top DUT (.*);
  bioc_chan_model u_chan (.clk_i(CLK_I), .rst_n_i(RESETN_I), .ior_n_i(CHAN_IOR_N_O),
    .iow_n_i(CHAN_IOW_N_O), .rd_cnt_o(ch_rd), .wr_cnt_o(ch_wr));

  always #4 CLK_I = ~CLK_I;
  // A hung handshake cannot stall the run past this ceiling.
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One host cycle; outputs are sampled late in the strobe, after the three-clock lag.
  task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] d, input int hold);
    @(negedge CLK_I);
    ADDR_I = a;
    DATA_I = d;
    IOR_N_I = wr;
    IOW_N_I = !wr;
    repeat (hold) @(negedge CLK_I);
    rd_d = DATA_O;
    rd_oe = DATA_OE_O;
    s_fcs = FLOPPY_CHIP_SELECT_O;
    s_hds_n = HARD_DISK_SELECT_N_O;
    s_bufa_n = FLOPPY_BUFFER_ENABLE_A_N_O;
    s_bufb_n = FLOPPY_BUFFER_ENABLE_B_N_O;
    s_sb = STANDBY_O;
    IOR_N_I = 1'b1;
    IOW_N_I = 1'b1;
    repeat (5) @(negedge CLK_I);
  endtask

  task automatic wr_reg(input int i, input logic [7:0] d);
    if (i == 1) d[0] = 1'b0;
    io(1'b1, REGS[i], d, 5);
    sh[i] = (d & MASKS[i]) | (sh[i] & ~MASKS[i]);
  endtask

  // Register value as read, with live status levels folded in.
  function automatic logic [7:0] exp_reg(input int i);
    if (i == 1) return sh[1] | {PARITY_ERR_I, CHANNEL_CHECK_IN_I, TIMER2_OUT_I, 5'h00};
    if (i == 3) return sh[3] | {1'b0, RTC_CLK_I, 2'b00, RTC_RST_I, 3'h0};
    return sh[i];
  endfunction

  function automatic logic [15:0] exp_outs();
    return {3'h0, sh[0][1] & TIMER2_OUT_I, sh[2][7], sh[2][4], sh[2][2], sh[2][1], sh[3][5],
      sh[3][4] | DMA_ACK2_I, sh[4][0] | DMA_ACK3_I, sh[3][7], sh[5][0], sh[0][5], sh[0][4], sh[0][0]};
  endfunction

  function automatic logic [15:0] act_outs();
    return {3'h0, SPEAKER_O, PARALLEL_OE_O, SERIAL1_SEL_O, VIDEO_SEL_O, PARALLEL_SEL_O, SERIAL2_EN_O,
      DMA_ACK_CH2_O, DMA_ACK_CH3_O, DRIVE_TYPE_OUT_O, INDICATOR_O, CHK_DISABLE_O, PARITY_DISABLE_O,
      TIMER2_GATE_O};
  endfunction

  // Floppy claim, disk select level and whether the channel should take the cycle.
  function automatic logic [2:0] exp_sel(input logic [9:0] a);
    logic f, h;
    f = sh[2][3] && (a inside {[FLOPPY_BASE:FLOPPY_LAST]});
    h = sh[2][0] && (sh[4][1] ? (a inside {[DISK_LEGACY_BASE:DISK_LEGACY_LAST]})
      : (a inside {[DISK_AT_BASE:DISK_AT_LAST]}));
    return {f, !h, !(f | h)};
  endfunction

  // Main sequence: reset values, readback, random registers, decode, DMA, standby.
  initial begin
    int i, k, n0;
    logic [9:0] a;
    logic [2:0] e;
    logic wr;
    void'($urandom(78583));
    repeat (3) @(negedge CLK_I);
    RESETN_I = 1'b1;
    chk("outputs after reset", exp_outs(), act_outs());
    for (i = 0; i < 6; i++) begin
      io(1'b0, REGS[i], 8'h00, 5);
      chk("reset value", {8'h00, exp_reg(i)}, {8'h00, rd_d});
    end
    $display("test reset values done");
    io(1'b0, 10'h3EF, 8'h00, 5);
    chk("unmapped read", 16'h0000, {7'h00, rd_oe, rd_d});
    FLOPPY_STAT_A_I = 8'($urandom);
    FLOPPY_STAT_B_I = 8'($urandom);
    io(1'b0, OFF_FLOPPY_READBACK_A, 8'h00, 5);
    chk("readback a", {8'h01, FLOPPY_STAT_A_I}, {7'h00, rd_oe, rd_d});
    io(1'b0, OFF_FLOPPY_READBACK_B, 8'h00, 5);
    chk("readback b", {8'h01, 1'b0, FLOPPY_STAT_B_I[6:0]}, {7'h00, rd_oe, rd_d});
    $display("test readback done");
    for (k = 0; k < 24; k++) begin
      i = $urandom % 6;
      {PARITY_ERR_I, CHANNEL_CHECK_IN_I, TIMER2_OUT_I, RTC_CLK_I, RTC_RST_I} = 5'($urandom);
      wr_reg(i, 8'($urandom));
      io(1'b0, REGS[i], 8'h00, 5);
      chk("register read", {8'h00, exp_reg(i)}, {8'h00, rd_d});
      chk("control outputs", exp_outs(), act_outs());
    end
    $display("test random registers done");
    wr_reg(3, 8'h00);
    for (k = 0; k < 16; k++) begin
      wr_reg(2, 8'($urandom));
      wr_reg(4, {6'h00, 1'($urandom), 1'b0});
      case ($urandom % 5)
        0: a = 10'h3F2 + 10'($urandom % 6);
        1: a = DISK_AT_BASE + 10'($urandom % 8);
        2: a = DISK_LEGACY_BASE + 10'($urandom % 8);
        3: a = 10'h328;
        default: a = 10'h3EF;
      endcase
      wr = 1'($urandom);
      e = exp_sel(a);
      n0 = wr ? ch_wr : ch_rd;
      io(wr, a, 8'($urandom), 5);
      chk("chip selects", {14'h0000, e[2:1]}, {14'h0000, s_fcs, s_hds_n});
      chk("channel cycles", 16'(e[0]), 16'((wr ? ch_wr : ch_rd) - n0));
      if (e[2]) chk("floppy buffers", {14'h0000, wr, !wr}, {14'h0000, s_bufa_n, s_bufb_n});
    end
    $display("test decode done");
    wr_reg(2, 8'h01);
    wr_reg(4, 8'h00);
    {DMA_ACK2_I, DMA_ACK3_I} = 2'b11;
    repeat (6) @(negedge CLK_I);
    chk("dma acks on", 16'h0006, {13'h0000, DMA_ACK_CH2_O, DMA_ACK_CH3_O, HARD_DISK_SELECT_N_O});
    {DMA_ACK2_I, DMA_ACK3_I} = 2'b00;
    repeat (6) @(negedge CLK_I);
    chk("dma acks off", 16'h0001, {13'h0000, DMA_ACK_CH2_O, DMA_ACK_CH3_O, HARD_DISK_SELECT_N_O});
    $display("test dma done");
    for (k = 0; k < 3; k++) begin
      io(1'b1, OFF_STANDBY_ARM, (k == 2) ? 8'h00 : 8'h01, 5);
      if (k == 1) io(1'b0, OFF_SYSTEM_CONTROL, 8'h00, 5);
      io(1'b0, OFF_STANDBY_TRIGGER, 8'h00, 10);
      chk("standby held", 16'(k == 0), {15'h0000, s_sb});
      chk("standby left", 16'h0000, {15'h0000, STANDBY_O});
    end
    $display("test standby done");
    conclude();
  end
endmodule
